// [hw/level_filter.sv]
// Glitch filter: output follows input only after a steady run
`timescale 1ns/1ps
module level_filter #(
	parameter int        STEADY_CYC = 16,
	parameter logic      INIT       = 1'b1
) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic level_in,
	output logic      level_out
);
	localparam int CW = $clog2(STEADY_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          lvl;
	} filt_state_t;

	filt_state_t state_r;
	filt_state_t state_nxt;

	initial begin
		if (STEADY_CYC < 1) begin
			$error("level_filter needs STEADY_CYC of at least one");
		end
	end

	always_comb begin
		state_nxt = state_r;
		if (level_in == state_r.lvl) begin
			state_nxt.cnt = '0;
		end else if (state_r.cnt >= CW'(STEADY_CYC - 1)) begin
			state_nxt.lvl = level_in;
			state_nxt.cnt = '0;
		end else begin
			state_nxt.cnt = state_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= '{cnt: '0, lvl: INIT};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign level_out = state_r.lvl;
endmodule

// [hw/sup_dog_pkg.sv]
// Shared constants, types and timing figures for the supervisor watchdog
package sup_dog_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;

	// Figures as printed, in their own units
	localparam int MANUAL_RESET_DELAY_NS = 250;
	localparam int MR_GLITCH_NS          = 200;
	localparam int EN_GLITCH_NS          = 300;
	localparam int KICK_MIN_WIDTH_NS     = 1000;
	localparam int SETTLE_US             = 300;
	localparam int PULSE_WIDTH_MS        = 100;

	// Least times round up, longest round down, never below one cycle
	localparam int MR_DELAY_CYC = (MANUAL_RESET_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int MR_GLITCH_CYC = (MR_GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int EN_GLITCH_CYC = (EN_GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int KICK_MIN_CYC = (KICK_MIN_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_US * 1000) / CLK_NS;
	localparam int PULSE_CYC = PULSE_WIDTH_MS * (CLK_HZ / 1000);

	// Defaults for factory-set periods; not given, plain choices
	localparam int HOLD_CYC_DEF    = 10_000_000;
	localparam int STARTUP_CYC_DEF = 50_000_000;
	localparam int TIMEOUT_CYC_DEF = 50_000_000;

	localparam int CNT_W = 32;

	typedef enum logic [4:0] {
		ST_RESET   = 5'h01,
		ST_HOLD    = 5'h02,
		ST_STARTUP = 5'h04,
		ST_WATCH   = 5'h08,
		ST_PULSE   = 5'h10
	} dog_state_t;

	typedef struct packed {
		logic kick;
		logic mr_or_en;
		logic supply_low_n;
	} pin_set_t;
endpackage

// [hw/supervisor_watchdog_reset.sv]
// Supply supervisor with reset hold and kick watchdog
`timescale 1ns/1ps
module supervisor_watchdog_reset #(
	parameter bit ENABLE_BUILD = 1'b0,
	parameter int HOLD_CYC     = sup_dog_pkg::HOLD_CYC_DEF,
	parameter int STARTUP_CYC  = sup_dog_pkg::STARTUP_CYC_DEF,
	parameter int TIMEOUT_CYC  = sup_dog_pkg::TIMEOUT_CYC_DEF,
	parameter int PULSE_CYC    = sup_dog_pkg::PULSE_CYC,
	parameter int SETTLE_CYC   = sup_dog_pkg::SETTLE_CYC
) (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic supply_low_in,
	input  wire logic manual_reset_n_in,
	input  wire logic dog_enable_in,
	input  wire logic kick_input_in,
	input  wire logic kick_float_in,
	output logic      supply_reset_n_out,
	output logic      timeout_pulse_n_out,
	output logic      timeout_pulse_n_oe_out
);
	localparam int W = sup_dog_pkg::CNT_W;

	initial begin
		if (HOLD_CYC < 1 || STARTUP_CYC < 1 || TIMEOUT_CYC < 2 || SETTLE_CYC < 1) begin
			$error("supervisor_watchdog_reset periods must be positive");
		end
		if (PULSE_CYC < 1) begin
			$error("supervisor_watchdog_reset pulse width must be positive");
		end
	end

	// Two-stage synchronisers; stage one read only by stage two
	sup_dog_pkg::pin_set_t meta_r;
	sup_dog_pkg::pin_set_t sync_r;
	logic                  float_meta_r;
	logic                  float_sync_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r       <= '{kick: 1'b0, mr_or_en: 1'b1, supply_low_n: 1'b0};
			sync_r       <= '{kick: 1'b0, mr_or_en: 1'b1, supply_low_n: 1'b0};
			float_meta_r <= 1'b1;
			float_sync_r <= 1'b1;
		end else begin
			// Shared pin position picks its role by build
			meta_r       <= '{kick: kick_input_in,
				mr_or_en: ENABLE_BUILD ? dog_enable_in : manual_reset_n_in,
				supply_low_n: ~supply_low_in};
			sync_r       <= meta_r;
			float_meta_r <= kick_float_in;
			float_sync_r <= float_meta_r;
		end
	end

	// Pull-up: an open manual reset pin is modelled as high, so reset resets
	// to inactive and the filter holds off any short low
	logic mr_filt;
	logic en_filt;

	level_filter #(
		.STEADY_CYC (ENABLE_BUILD ? sup_dog_pkg::EN_GLITCH_CYC : sup_dog_pkg::MR_GLITCH_CYC),
		.INIT       (ENABLE_BUILD ? 1'b0 : 1'b1)
	) u_pin_filter (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.level_in  (sync_r.mr_or_en),
		.level_out (mr_filt)
	);

	// Filter covers part of the 250ns delay; this four-stage shift adds four more cycles
	logic [3:0] mr_dly_r;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mr_dly_r <= 4'hF;
		end else begin
			mr_dly_r <= {mr_dly_r[2:0], mr_filt};
		end
	end

	assign en_filt = ENABLE_BUILD ? mr_filt : 1'b1;

	logic reset_cause;
	assign reset_cause = ~sync_r.supply_low_n | (~ENABLE_BUILD & ~mr_dly_r[3]);

	typedef struct packed {
		sup_dog_pkg::dog_state_t st;
		logic [W-1:0]            cnt;
		logic [W-1:0]            settle;
		logic [W-1:0]            high_cnt;
		logic                    kick_prev;
		logic                    en_prev;
		logic                    rst_n;
		logic                    pulse_n;
	} dog_regs_t;

	dog_regs_t s_r;
	dog_regs_t s_nxt;

	logic kick_fall;
	logic wide_pulse;
	logic dog_on;
	logic settled;

	always_comb begin
		s_nxt = s_r;
		kick_fall = s_r.kick_prev & ~sync_r.kick;
		wide_pulse = s_r.high_cnt >= W'(sup_dog_pkg::KICK_MIN_CYC);
		dog_on = ENABLE_BUILD ? en_filt : ~float_sync_r;
		settled = s_r.settle == '0;

		s_nxt.kick_prev = sync_r.kick;
		s_nxt.en_prev = en_filt;
		if (sync_r.kick) begin
			s_nxt.high_cnt = wide_pulse ? s_r.high_cnt : s_r.high_cnt + W'(1);
		end else begin
			s_nxt.high_cnt = '0;
		end

		// Settle window restarts on every enable rise
		if (ENABLE_BUILD && en_filt && !s_r.en_prev) begin
			s_nxt.settle = W'(SETTLE_CYC);
		end else if (!settled) begin
			s_nxt.settle = s_r.settle - W'(1);
		end

		if (reset_cause) begin
			s_nxt.st = sup_dog_pkg::ST_RESET;
			s_nxt.rst_n = 1'b0;
			s_nxt.pulse_n = 1'b1;
			s_nxt.cnt = '0;
		end else begin
			case (s_r.st)
				sup_dog_pkg::ST_RESET: begin
					s_nxt.st = sup_dog_pkg::ST_HOLD;
					s_nxt.cnt = '0;
				end
				sup_dog_pkg::ST_HOLD: begin
					if (s_r.cnt >= W'(HOLD_CYC - 1)) begin
						s_nxt.st = sup_dog_pkg::ST_STARTUP;
						s_nxt.rst_n = 1'b1;
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + W'(1);
					end
				end
				sup_dog_pkg::ST_STARTUP: begin
					// Kicks here are dropped; fixed length by build only
					if (s_r.cnt >= W'(STARTUP_CYC - 1)) begin
						s_nxt.st = sup_dog_pkg::ST_WATCH;
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + W'(1);
					end
				end
				sup_dog_pkg::ST_WATCH: begin
					if (!dog_on || !settled) begin
						s_nxt.cnt = '0;
					end else if (kick_fall && wide_pulse) begin
						s_nxt.cnt = '0;
					end else if (s_r.cnt >= W'(TIMEOUT_CYC - 1)) begin
						s_nxt.st = sup_dog_pkg::ST_PULSE;
						s_nxt.pulse_n = 1'b0;
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + W'(1);
					end
				end
				sup_dog_pkg::ST_PULSE: begin
					// Kicks ignored while pulse is low
					if (s_r.cnt >= W'(PULSE_CYC - 1)) begin
						s_nxt.st = sup_dog_pkg::ST_WATCH;
						s_nxt.pulse_n = 1'b1;
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + W'(1);
					end
				end
				default: begin
					s_nxt.st = sup_dog_pkg::ST_RESET;
					s_nxt.rst_n = 1'b0;
					s_nxt.pulse_n = 1'b1;
					s_nxt.cnt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_r <= '{st: sup_dog_pkg::ST_RESET, cnt: '0, settle: '0, high_cnt: '0,
				kick_prev: 1'b0, en_prev: 1'b0, rst_n: 1'b0, pulse_n: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Timeout pulse is open drain: only ever pulls low, enable low while driving; reset is driven both ways
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			supply_reset_n_out     <= 1'b0;
			timeout_pulse_n_out    <= 1'b0;
			timeout_pulse_n_oe_out <= 1'b1;
		end else begin
			supply_reset_n_out     <= s_nxt.rst_n;
			timeout_pulse_n_out    <= 1'b0;
			timeout_pulse_n_oe_out <= s_nxt.pulse_n;
		end
	end
endmodule

// [test/mcu_kicker.sv]
// Processor model that toggles the kick line
`timescale 1ns/1ps
module mcu_kicker (
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic [7:0] high_in,
	input  wire logic [7:0] low_in,
	output logic            kick_out
);
	int cnt = 0;
	initial kick_out = 1'b1;
	// Set and cleared at separate points, never a tight pulse
	always @(negedge clk_in) begin
		cnt = cnt + 1;
		if (!run_in)
			cnt = 0;
		else if (cnt >= int'(kick_out ? high_in : low_in)) begin
			kick_out <= ~kick_out;
			cnt = 0;
		end
	end
endmodule

// [test/sup_dog_sva.sv]
// Port-level checker for the supervisor watchdog
`timescale 1ns/1ps
module sup_dog_sva #(
	parameter int HOLD_CYC    = 20,
	parameter int STARTUP_CYC = 50,
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic supply_low_in,
	input wire logic manual_reset_n_in,
	input wire logic kick_input_in,
	input wire logic kick_float_in,
	input wire logic supply_reset_n_out,
	input wire logic timeout_pulse_n_out,
	input wire logic timeout_pulse_n_oe_out
);
	int   hi_r;
	int   quiet_r;
	int   mr_low_r;
	logic oe;
	assign oe = timeout_pulse_n_oe_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Quiet count restarts in reset, on float, at pulse end, and on falls after a wide high
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hi_r <= 0;
			quiet_r <= 0;
			mr_low_r <= 0;
		end else begin
			hi_r <= kick_input_in ? hi_r + 1 : 0;
			mr_low_r <= manual_reset_n_in ? 0 : mr_low_r + 1;
			if (!supply_reset_n_out || kick_float_in || $rose(oe) ||
			    ($fell(kick_input_in) && hi_r >= 52))
				quiet_r <= 0;
			else
				quiet_r <= quiet_r + 1;
		end
	end
	a_pulse_width: assert property ($fell(oe) |-> (!oe)[*8] ##1 (!oe)[*2] ##1 oe)
		else $error("timeout pulse width wrong");
	a_drain_low: assert property (!timeout_pulse_n_out)
		else $error("timeout data not low");
	a_supply_reset: assert property (supply_low_in[*7] |-> !supply_reset_n_out)
		else $error("reset not held in supply low");
	a_supply_hold: assert property ($fell(supply_low_in) |-> ##HOLD_CYC !supply_reset_n_out
		##[1:12] supply_reset_n_out)
		else $error("supply hold period wrong");
	a_manual_delay: assert property (mr_low_r >= 24 |-> !supply_reset_n_out)
		else $error("manual reset not asserted");
	a_manual_hold: assert property ($rose(manual_reset_n_in) && mr_low_r > 24 |->
		##HOLD_CYC !supply_reset_n_out ##[1:20] supply_reset_n_out)
		else $error("manual hold period wrong");
	a_mr_glitch: assert property ($rose(manual_reset_n_in) && mr_low_r < 9 &&
		supply_reset_n_out |-> ##8 supply_reset_n_out[*8])
		else $error("manual glitch caused reset");
	a_quiet_min: assert property ($fell(oe) |-> quiet_r >= TIMEOUT_CYC - 2)
		else $error("timeout came early");
	a_quiet_max: assert property (quiet_r == STARTUP_CYC + TIMEOUT_CYC + 6 |-> !oe)
		else $error("timeout missing");
	a_fault_quiet: assert property ($fell(oe) |-> supply_reset_n_out && !kick_float_in)
		else $error("timeout while ignored");
	c_pulse: cover property ($fell(oe));
	c_release: cover property ($rose(supply_reset_n_out));
	c_glitch: cover property ($rose(manual_reset_n_in) && mr_low_r < 9);
endmodule
bind supervisor_watchdog_reset sup_dog_sva #(.HOLD_CYC(HOLD_CYC), .STARTUP_CYC(STARTUP_CYC),
	.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.supply_low_in(supply_low_in), .manual_reset_n_in(manual_reset_n_in),
	.kick_input_in(kick_input_in), .kick_float_in(kick_float_in),
	.supply_reset_n_out(supply_reset_n_out), .timeout_pulse_n_out(timeout_pulse_n_out),
	.timeout_pulse_n_oe_out(timeout_pulse_n_oe_out));

// [test/supervisor_watchdog_reset_tb_top.sv]
// Self-checking bench for the supervisor watchdog, manual and enable builds
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb_top;
	localparam int HOLD = 20;
	localparam int START = 50;
	localparam int TOUT = 200;
	localparam int PULSE = 10;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        supply_low = 1'b0;
	logic        mr_n = 1'b1;
	logic        kick_float = 1'b0;
	logic        run = 1'b0;
	logic [7:0]  hi_w = 8'h40;
	logic [7:0]  lo_w = 8'h40;
	logic [31:0] seed = 32'h4A07FA51;
	logic        kick;
	logic        rst_n;
	logic        drv_n;
	logic        oe_n;
	logic        dog_line;
	logic        dog_en = 1'b0;
	logic        rst2_n;
	logic        drv2_n;
	logic        oe2_n;
	logic        dog_line2;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          n;
	// Open-drain line with pull-up
	assign dog_line = oe_n ? 1'b1 : drv_n;
	assign dog_line2 = oe2_n ? 1'b1 : drv2_n;
	always #10 clk_in = ~clk_in;
	supervisor_watchdog_reset #(.HOLD_CYC(HOLD), .STARTUP_CYC(START), .TIMEOUT_CYC(TOUT),
		.PULSE_CYC(PULSE), .SETTLE_CYC(30)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.supply_low_in(supply_low), .manual_reset_n_in(mr_n), .dog_enable_in(1'b0),
		.kick_input_in(kick), .kick_float_in(kick_float), .supply_reset_n_out(rst_n),
		.timeout_pulse_n_out(drv_n), .timeout_pulse_n_oe_out(oe_n));
	// Enable build ignores its float port, so it carries the dog-off state
	// and lets the checker's quiet count restart while the dog is disabled
	supervisor_watchdog_reset #(.ENABLE_BUILD(1'b1), .HOLD_CYC(HOLD), .STARTUP_CYC(START),
		.TIMEOUT_CYC(TOUT), .PULSE_CYC(PULSE), .SETTLE_CYC(30)) i_dut_en (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .supply_low_in(supply_low), .manual_reset_n_in(1'b1),
		.dog_enable_in(dog_en), .kick_input_in(kick), .kick_float_in(~dog_en),
		.supply_reset_n_out(rst2_n), .timeout_pulse_n_out(drv2_n),
		.timeout_pulse_n_oe_out(oe2_n));
	mcu_kicker i_mcu (.clk_in(clk_in), .run_in(run), .high_in(hi_w), .low_in(lo_w),
		.kick_out(kick));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic final_report;
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input int lo, input int hi, input int seen);
		samples_checked++;
		if (seen < lo || seen > hi) begin
			fail_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask
	// Cycles until the line shows v; a must-wait that runs out ends the run
	task automatic wait_for(input int dog, input logic v, input int lim, input bit must,
		output int cyc);
		cyc = 0;
		while ((((dog == 2) ? dog_line2 : (dog == 1) ? dog_line : rst_n) !== v) &&
		       cyc < lim) begin
			@(negedge clk_in);
			cyc++;
		end
		if (must && cyc >= lim) begin
			fail_count++;
			final_report();
		end
	endtask
	initial begin
		repeat (16) @(negedge clk_in);
		rst_b_in = 1'b1;
		wait_for(0, 1'b1, 100, 1, n);
		check("reset hold", HOLD, HOLD + 6, n);
		wait_for(1, 1'b0, 400, 1, n);
		check("first timeout", START + TOUT, START + TOUT + 6, n);
		wait_for(1, 1'b1, 40, 1, n);
		check("pulse width", PULSE, PULSE, n);
		wait_for(1, 1'b0, 400, 1, n);
		check("restart timeout", TOUT - 1, TOUT + 2, n);
		wait_for(1, 1'b1, 40, 1, n);
		run = 1'b1;
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			hi_w = 8'd55 + 8'(seed[4:0]);
			lo_w = 8'd20 + 8'(seed[12:8]);
			wait_for(1, 1'b0, TOUT, 0, n);
			check("kicked quiet", TOUT, TOUT, n);
		end
		hi_w = 8'd20;
		lo_w = 8'd20;
		wait_for(1, 1'b0, TOUT + 200, 1, n);
		check("narrow kicks", 1, TOUT + 4, n);
		wait_for(1, 1'b1, 40, 1, n);
		run = 1'b0;
		kick_float = 1'b1;
		wait_for(1, 1'b0, 2 * TOUT, 0, n);
		check("floating kick", 2 * TOUT, 2 * TOUT, n);
		kick_float = 1'b0;
		mr_n = 1'b0;
		repeat (8) @(negedge clk_in);
		mr_n = 1'b1;
		wait_for(0, 1'b0, 40, 0, n);
		check("manual glitch", 40, 40, n);
		mr_n = 1'b0;
		wait_for(0, 1'b0, 30, 1, n);
		check("manual delay", 10, 25, n);
		wait_for(0, 1'b1, 40, 0, n);
		check("manual held", 40, 40, n);
		mr_n = 1'b1;
		wait_for(0, 1'b1, 60, 1, n);
		check("manual hold", HOLD, HOLD + 20, n);
		supply_low = 1'b1;
		wait_for(0, 1'b0, 10, 1, n);
		check("supply low", 1, 6, n);
		repeat (30) @(negedge clk_in);
		supply_low = 1'b0;
		wait_for(0, 1'b1, 60, 1, n);
		check("supply hold", HOLD, HOLD + 6, n);
		check("enable build reset", 1, 1, int'(rst2_n));
		repeat (60) @(negedge clk_in);
		dog_en = 1'b1;
		wait_for(2, 1'b0, 300, 1, n);
		check("enable settle", 30 + TOUT, 30 + TOUT + 24, n);
		wait_for(2, 1'b1, 40, 1, n);
		dog_en = 1'b0;
		wait_for(2, 1'b0, 2 * TOUT, 0, n);
		check("enable low", 2 * TOUT, 2 * TOUT, n);
		final_report();
	end
endmodule
